// ---- hw/epf_pkg.sv ----
// Purpose: Shared constants for the enhanced prefetch unit.
// Assumes: 32-bit AHB-Lite register slave.
// Notes: Segment mode codes are set by the translator.
package epf_pkg;
   // ==========================================
   // Instruction encoding
   localparam logic [5:0] EPF_MAJOR = 6'h18;
   localparam logic [3:0] EPF_GRP = 4'ha;
   localparam logic [2:0] EPF_SUB = 3'h2;
   localparam int EPF_MAJ_LSB = 26;
   localparam int EPF_HINT_LSB = 21;
   localparam int EPF_GRP_LSB = 12;
   localparam int EPF_SUB_LSB = 9;
   localparam int EPF_OFS_W = 9;
   // ==========================================
   // Hint codes
   localparam logic [4:0] EPF_H_LOAD = 5'h00;
   localparam logic [4:0] EPF_H_STORE = 5'h01;
   localparam logic [4:0] EPF_H_LD_STRM = 5'h04;
   localparam logic [4:0] EPF_H_ST_STRM = 5'h05;
   localparam logic [4:0] EPF_H_LD_RET = 5'h06;
   localparam logic [4:0] EPF_H_ST_RET = 5'h07;
   localparam logic [4:0] EPF_H_WBINV = 5'h19;
   localparam logic [4:0] EPF_H_ZERO = 5'h1e;
   // ==========================================
   // Segment access modes
   localparam logic [2:0] EPF_SEG_UNMAPPED = 3'h1;
   localparam logic [2:0] EPF_SEG_MAPPED = 3'h2;
   localparam logic [2:0] EPF_SEG_USER_MAP = 3'h3;
   // ==========================================
   // Registers
   localparam logic [3:0] EPF_REG_CTRL = 4'h0;
   localparam logic [3:0] EPF_REG_STAT = 4'h4;
   localparam logic [3:0] EPF_REG_EXEC = 4'h8;
   localparam logic [3:0] EPF_REG_SUPP = 4'hc;
   localparam logic [2:0] EPF_CTRL_RST = 3'h1;
   localparam int EPF_C_EVA = 0;
   localparam int EPF_C_REPORT = 1;
   localparam int EPF_C_INVCLN = 2;
   // ==========================================
   // Types
   typedef enum logic [2:0] {EPF_OP_PROBE, EPF_OP_FETCH, EPF_OP_WB_VICTIM,
      EPF_OP_WB_INVAL, EPF_OP_INVAL, EPF_OP_ZERO} epf_op_t;
   typedef enum logic [1:0] {EPF_PL_NORMAL, EPF_PL_STREAM, EPF_PL_RETAIN} epf_place_t;
   typedef enum logic [2:0] {EPF_ACT_NOP, EPF_ACT_FETCH, EPF_ACT_WBINV, EPF_ACT_ZERO} epf_act_t;
   typedef enum logic [1:0] {EPF_EXC_NONE, EPF_EXC_RI, EPF_EXC_CPU, EPF_EXC_BUS} epf_exc_t;
endpackage

// ---- hw/epf_prefetch_unit.sv ----
// Purpose: Decode and carry out the enhanced prefetch instruction.
// Assumes: Translator and cache answer with valid pulses.
// Notes: Registers sit on an AHB-Lite slave port.
`timescale 1ns/1ps
module epf_prefetch_unit
   import epf_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int PADDR_W = 32
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic issue_valid,
   output logic issue_ready,
   input wire logic [31:0] instr_word,
   input wire logic [ADDR_W-1:0] base_value,
   input wire logic system_control_coprocessor_en,
   output logic done_valid,
   output logic done_match,
   output epf_exc_t done_exc,
   output logic xlat_req_valid,
   output logic [ADDR_W-1:0] xlat_vaddr,
   output logic xlat_user_map,
   input wire logic xlat_resp_valid,
   input wire logic [2:0] xlat_seg_mode,
   input wire logic xlat_hit,
   input wire logic xlat_fault,
   input wire logic xlat_cached,
   input wire logic xlat_coherent,
   input wire logic [2:0] xlat_attr,
   input wire logic [PADDR_W-1:0] xlat_paddr,
   input wire logic order_clear,
   output logic cache_req_valid,
   input wire logic cache_req_ready,
   output epf_op_t cache_req_op,
   output logic [PADDR_W-1:0] cache_req_paddr,
   output logic [2:0] cache_req_attr,
   output logic cache_req_coherent,
   output epf_place_t cache_req_place,
   output logic cache_req_store,
   input wire logic cache_done,
   input wire logic cache_err,
   input wire logic probe_hit,
   input wire logic probe_dirty,
   input wire logic probe_locked,
   input wire logic victim_valid,
   input wire logic victim_dirty,
   input wire logic victim_locked
);
   // ==========================================
   // Elaboration checks
   if (ADDR_W < 16 || PADDR_W < 16) begin : g_bad_width
      $error("Address widths below 16 bits are not served.");
   end

   // ==========================================
   // Hint decoding
   function automatic epf_act_t hint_act(input logic [4:0] h);
      case (h)
         EPF_H_LOAD, EPF_H_STORE, EPF_H_LD_STRM, EPF_H_ST_STRM,
         EPF_H_LD_RET, EPF_H_ST_RET: hint_act = EPF_ACT_FETCH;
         EPF_H_WBINV: hint_act = EPF_ACT_WBINV;
         EPF_H_ZERO: hint_act = EPF_ACT_ZERO;
         default: hint_act = EPF_ACT_NOP;
      endcase
   endfunction

   function automatic epf_place_t hint_place(input logic [4:0] h);
      case (h)
         EPF_H_LD_STRM, EPF_H_ST_STRM: hint_place = EPF_PL_STREAM;
         EPF_H_LD_RET, EPF_H_ST_RET: hint_place = EPF_PL_RETAIN;
         default: hint_place = EPF_PL_NORMAL;
      endcase
   endfunction

   typedef enum logic [2:0] {ST_IDLE, ST_XLAT, ST_ISSUE, ST_WAIT, ST_DONE} epf_state_t;

   epf_state_t state_ff, nxt_state;
   logic [4:0] hint_ff;
   logic [ADDR_W-1:0] ea_ff;
   logic [PADDR_W-1:0] paddr_ff;
   logic [2:0] attr_ff;
   logic coh_ff;
   epf_op_t op_ff, nxt_op, pend_ff, nxt_pend;
   logic pend_vld_ff, nxt_pend_vld;
   epf_exc_t exc_ff, nxt_exc;
   logic match_ff, nxt_match;
   logic err_ff, nxt_err;
   logic supp_ff, nxt_supp;
   logic [2:0] ctrl_ff;
   logic [31:0] exec_ff, supp_cnt_ff, rdata_ff;
   logic [3:0] wr_addr_ff;
   logic wr_pend_ff;

   // ==========================================
   // Instruction decode and address
   wire logic accept = issue_valid && issue_ready;
   wire logic is_eva_prefetch_instr = (instr_word[31:EPF_MAJ_LSB] == EPF_MAJOR) &&
      (instr_word[EPF_GRP_LSB+3:EPF_GRP_LSB] == EPF_GRP) &&
      (instr_word[EPF_SUB_LSB+2:EPF_SUB_LSB] == EPF_SUB);
   wire logic [EPF_OFS_W-1:0] ofs = instr_word[EPF_OFS_W-1:0];
   wire logic [ADDR_W-1:0] ofs_ext = {{(ADDR_W-EPF_OFS_W){ofs[EPF_OFS_W-1]}}, ofs};
   wire logic [ADDR_W-1:0] ea = base_value + ofs_ext;
   wire logic enhanced_vaddr_config_bit = ctrl_ff[EPF_C_EVA];
   wire epf_act_t act = hint_act(hint_ff);
   wire logic seg_ok = (xlat_seg_mode == EPF_SEG_UNMAPPED) ||
      (xlat_seg_mode == EPF_SEG_MAPPED) || (xlat_seg_mode == EPF_SEG_USER_MAP);
   wire logic xlat_bad = xlat_fault || !xlat_hit;
   wire logic probe_back = (state_ff == ST_WAIT) && cache_done && (op_ff == EPF_OP_PROBE);
   wire logic victim_free = !probe_hit && !victim_locked;
   wire logic victim_wb = victim_valid && victim_dirty;

   // ==========================================
   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_pend = pend_ff;
      nxt_pend_vld = pend_vld_ff;
      nxt_exc = exc_ff;
      nxt_match = match_ff;
      nxt_err = err_ff;
      nxt_supp = supp_ff;
      case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_match = is_eva_prefetch_instr;
               nxt_exc = EPF_EXC_NONE;
               nxt_err = 1'b0;
               nxt_supp = 1'b0;
               nxt_pend_vld = 1'b0;
               nxt_state = ST_DONE;
               if (!is_eva_prefetch_instr) begin
                  nxt_exc = EPF_EXC_NONE;
               end else if (!enhanced_vaddr_config_bit) begin
                  nxt_exc = EPF_EXC_RI;
               end else if (!system_control_coprocessor_en) begin
                  nxt_exc = EPF_EXC_CPU;
               end else begin
                  nxt_state = ST_XLAT;
               end
            end
         end
         ST_XLAT: begin
            if (xlat_resp_valid) begin
               nxt_state = ST_DONE;
               nxt_op = EPF_OP_PROBE;
               if (!seg_ok) begin
                  nxt_exc = EPF_EXC_RI;
               end else if (xlat_bad) begin
                  nxt_supp = 1'b1;
               end else if (xlat_cached && act != EPF_ACT_NOP) begin
                  nxt_state = ST_ISSUE;
               end
            end
         end
         ST_ISSUE: begin
            if (cache_req_valid && cache_req_ready) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cache_done) begin
               nxt_err = err_ff || cache_err;
               nxt_state = ST_DONE;
               if (op_ff == EPF_OP_PROBE) begin
                  case (act)
                     EPF_ACT_FETCH, EPF_ACT_ZERO: begin
                        if (victim_free) begin
                           nxt_state = ST_ISSUE;
                           nxt_pend = (act == EPF_ACT_ZERO) ? EPF_OP_ZERO : EPF_OP_FETCH;
                           nxt_pend_vld = victim_wb;
                           nxt_op = victim_wb ? EPF_OP_WB_VICTIM : nxt_pend;
                        end
                     end
                     EPF_ACT_WBINV: begin
                        if (probe_hit && !probe_locked) begin
                           if (probe_dirty) begin
                              nxt_state = ST_ISSUE;
                              nxt_op = EPF_OP_WB_INVAL;
                           end else if (ctrl_ff[EPF_C_INVCLN]) begin
                              nxt_state = ST_ISSUE;
                              nxt_op = EPF_OP_INVAL;
                           end
                        end
                     end
                     default: nxt_state = ST_DONE;
                  endcase
               end else if (pend_vld_ff) begin
                  nxt_state = ST_ISSUE;
                  nxt_op = pend_ff;
                  nxt_pend_vld = 1'b0;
               end
               if (nxt_state == ST_DONE && nxt_err && ctrl_ff[EPF_C_REPORT]) begin
                  nxt_exc = EPF_EXC_BUS;
               end
            end
         end
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         op_ff <= EPF_OP_PROBE;
         pend_ff <= EPF_OP_PROBE;
         pend_vld_ff <= 1'b0;
         exc_ff <= EPF_EXC_NONE;
         match_ff <= 1'b0;
         err_ff <= 1'b0;
         supp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         pend_ff <= nxt_pend;
         pend_vld_ff <= nxt_pend_vld;
         exc_ff <= nxt_exc;
         match_ff <= nxt_match;
         err_ff <= nxt_err;
         supp_ff <= nxt_supp;
      end
   end

   // Operands are captured once; the cache sees the attributes of this address only.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hint_ff <= 5'h00;
         ea_ff <= '0;
         paddr_ff <= '0;
         attr_ff <= 3'h0;
         coh_ff <= 1'b0;
      end else begin
         if (accept) begin
            hint_ff <= instr_word[EPF_HINT_LSB+4:EPF_HINT_LSB];
            ea_ff <= ea;
         end
         if (state_ff == ST_XLAT && xlat_resp_valid) begin
            paddr_ff <= xlat_paddr;
            attr_ff <= xlat_attr;
            coh_ff <= xlat_coherent;
         end
      end
   end

   // ==========================================
   // Outputs
   assign issue_ready = (state_ff == ST_IDLE);
   assign done_valid = (state_ff == ST_DONE);
   assign done_match = match_ff;
   assign done_exc = exc_ff;
   assign xlat_req_valid = (state_ff == ST_XLAT);
   assign xlat_vaddr = ea_ff;
   assign xlat_user_map = 1'b1;
   // Requests wait for older memory traffic so the barrier ordering holds.
   assign cache_req_valid = (state_ff == ST_ISSUE) && order_clear;
   assign cache_req_op = op_ff;
   assign cache_req_paddr = paddr_ff;
   assign cache_req_attr = attr_ff;
   assign cache_req_coherent = coh_ff;
   assign cache_req_place = hint_place(hint_ff);
   assign cache_req_store = hint_ff[0];

   // ==========================================
   // Register slave
   wire logic bus_take = hsel && hready && htrans[1];
   wire logic bus_wr = wr_pend_ff;
   wire logic cnt_exec = done_valid && match_ff && exc_ff == EPF_EXC_NONE;
   wire logic cnt_supp = done_valid && supp_ff;
   wire logic clr_exec = bus_wr && wr_addr_ff == EPF_REG_EXEC;
   wire logic clr_supp = bus_wr && wr_addr_ff == EPF_REG_SUPP;
   wire logic [31:0] stat_word = {28'h0, supp_ff, exc_ff, state_ff != ST_IDLE};
   wire logic [31:0] rd_mux = (haddr[3:0] == EPF_REG_CTRL) ? {29'h0, ctrl_ff} :
      (haddr[3:0] == EPF_REG_STAT) ? stat_word :
      (haddr[3:0] == EPF_REG_EXEC) ? exec_ff :
      (haddr[3:0] == EPF_REG_SUPP) ? supp_cnt_ff : 32'h0;
   wire logic rd_hit = haddr[31:4] == 28'h0;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   // An increment in the cycle of a clearing write survives as one count.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_ff <= EPF_CTRL_RST;
         exec_ff <= 32'h0;
         supp_cnt_ff <= 32'h0;
         rdata_ff <= 32'h0;
         wr_addr_ff <= 4'h0;
         wr_pend_ff <= 1'b0;
      end else begin
         wr_pend_ff <= bus_take && hwrite && haddr[31:4] == 28'h0;
         wr_addr_ff <= haddr[3:0];
         if (bus_take && !hwrite) begin
            rdata_ff <= rd_hit ? rd_mux : 32'h0;
         end
         if (bus_wr && wr_addr_ff == EPF_REG_CTRL) begin
            ctrl_ff <= hwdata[2:0];
         end
         exec_ff <= cnt_exec ? (clr_exec ? 32'h1 : exec_ff + 32'h1) : (clr_exec ? 32'h0 : exec_ff);
         supp_cnt_ff <= cnt_supp ? (clr_supp ? 32'h1 : supp_cnt_ff + 32'h1) :
            (clr_supp ? 32'h0 : supp_cnt_ff);
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   wire logic xl_ok = state_ff == ST_XLAT && xlat_resp_valid && seg_ok;

   chk_fault_silent: assert property (xl_ok && xlat_bad |=>
      done_valid && done_exc == EPF_EXC_NONE && supp_ff)
      else $error("Address fault was not suppressed.");

   chk_tlb_miss_quiet: assert property (xl_ok && !xlat_hit |->
      !cache_req_valid[*2])
      else $error("Translation miss moved data.");

   chk_uncached_none: assert property (xl_ok && !xlat_bad && !xlat_cached |=>
      done_valid ##1 !cache_req_valid)
      else $error("Uncached address issued a cache request.");

   chk_config_off: assert property (accept && is_eva_prefetch_instr &&
      !enhanced_vaddr_config_bit |=> done_valid && done_exc == EPF_EXC_RI)
      else $error("Disabled instruction did not raise reserved.");

   chk_cop_off: assert property (accept && is_eva_prefetch_instr && enhanced_vaddr_config_bit &&
      !system_control_coprocessor_en |=> done_exc == EPF_EXC_CPU)
      else $error("Coprocessor check missed.");

   chk_barrier_gate: assert property (state_ff == ST_ISSUE && !order_clear |->
      !cache_req_valid ##1 state_ff == ST_ISSUE)
      else $error("Request went out before older traffic completed.");

   chk_attr_follow: assert property (xl_ok && !xlat_bad && xlat_cached && act != EPF_ACT_NOP |=>
      cache_req_attr == $past(xlat_attr) && cache_req_coherent == $past(xlat_coherent))
      else $error("Request attribute differs from translation.");

   chk_locked_keep: assert property (probe_back && probe_hit && probe_locked &&
      act == EPF_ACT_WBINV |=> done_valid)
      else $error("Locked line was touched.");

   chk_zero_hit: assert property (probe_back && probe_hit && act == EPF_ACT_ZERO |=>
      done_valid && !cache_req_valid)
      else $error("Zero-fill acted on a hit.");

   chk_nop_hint: assert property (xl_ok && !xlat_bad && act == EPF_ACT_NOP |=>
      done_valid ##1 issue_ready)
      else $error("Unused hint did not finish as a no-op.");

   cov_zero_fill: cover property (cache_req_valid && cache_req_ready && cache_req_op == EPF_OP_ZERO);
   cov_wb_inval: cover property (cache_req_valid && cache_req_ready && cache_req_op == EPF_OP_WB_INVAL);
   cov_victim_fetch: cover property (cache_req_op == EPF_OP_WB_VICTIM ##[1:20] cache_req_op == EPF_OP_FETCH);
   cov_bus_err: cover property (done_valid && done_exc == EPF_EXC_BUS);
endmodule

// ---- tb/epf_far_model.sv ----
// Purpose: Far-side translator and cache handshake model.
// Assumes: The bench drives the attribute lines that go with each answer.
// Notes: With slow set, translator answers and cache done lag by three cycles; cache ready waits one cycle for a request.
`timescale 1ns/1ps
module epf_far_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic xlat_req_valid,
   output logic xlat_resp_valid,
   input wire logic cache_req_valid,
   output logic cache_req_ready,
   output logic cache_done
);
   // ==========
   // Answers
   wire logic [1:0] lag;
   logic [1:0] xcnt_ff;
   logic [1:0] ccnt_ff;
   logic pend_ff;
   assign lag = slow ? 2'h3 : 2'h0;
   always @(posedge clock) begin
      xlat_resp_valid <= 1'b0;
      cache_done <= 1'b0;
      if (sys_rst) begin
         xcnt_ff <= 2'h0;
         ccnt_ff <= 2'h0;
         pend_ff <= 1'b0;
         cache_req_ready <= 1'b0;
      end else begin
         if (xlat_req_valid && !xlat_resp_valid) begin
            xcnt_ff <= (xcnt_ff == lag) ? 2'h0 : xcnt_ff + 2'h1;
            xlat_resp_valid <= (xcnt_ff == lag);
         end
         // Ready drops at acceptance, so a second request cannot slip in before done.
         if (cache_req_valid && cache_req_ready) begin
            pend_ff <= 1'b1;
            cache_req_ready <= 1'b0;
         end else if (pend_ff) begin
            ccnt_ff <= (ccnt_ff == lag) ? 2'h0 : ccnt_ff + 2'h1;
            cache_done <= (ccnt_ff == lag);
            pend_ff <= (ccnt_ff != lag);
         end else begin
            cache_req_ready <= !slow || cache_req_valid;
         end
      end
   end
endmodule

// ---- tb/eva_prefetch_instruction_unit_bench.sv ----
// Purpose: Self-checking bench for the enhanced prefetch unit.
// Assumes: Zero-wait AHB-Lite slave, far side as in the model.
// Notes: Cache operations are recorded and compared per instruction.
`timescale 1ns/1ps
module eva_prefetch_instruction_unit_bench;
   import epf_pkg::*;
   // ==========
   // Signals
   logic clock = 0, sys_rst = 1, hsel = 0, hwrite = 0, issue_valid = 0, slow = 0, order_clear = 1;
   logic system_control_coprocessor_en = 1, t_hit = 1, t_flt = 0, t_cac = 1, t_coh = 1, t_st = 0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, t_seg = EPF_SEG_USER_MAP, t_attr = 3'h5;
   logic [31:0] haddr = 0, hwdata = 0, instr_word = 0, base_value = 0, d, exp_va = 0;
   logic [31:0] t_base = 32'h8000_0100, t_pa = 32'h0004_1230;
   logic [6:0] pv_q = 7'h0;
   epf_place_t t_pl = EPF_PL_NORMAL;
   wire logic hready, hreadyout, hresp, issue_ready, done_valid, done_match, xlat_req_valid, xlat_user_map;
   wire logic xlat_resp_valid, xlat_hit, xlat_fault, xlat_cached, xlat_coherent, cache_req_valid;
   wire logic cache_req_ready, cache_req_coherent, cache_req_store, cache_done, cache_err;
   wire logic probe_hit, probe_dirty, probe_locked, victim_valid, victim_dirty, victim_locked;
   wire logic [2:0] xlat_seg_mode, xlat_attr, cache_req_attr;
   wire logic [31:0] hrdata, xlat_vaddr, xlat_paddr, cache_req_paddr;
   epf_exc_t done_exc;
   epf_op_t cache_req_op;
   epf_place_t cache_req_place;
   epf_op_t ops[$];
   int bad_count = 0, tests_run = 0;
   localparam logic [8:0] E_PF = {EPF_OP_PROBE, EPF_OP_FETCH, EPF_OP_PROBE};
   localparam logic [8:0] E_P = {EPF_OP_PROBE, 6'h0};
   localparam logic [8:0] E_PWZ = {EPF_OP_PROBE, EPF_OP_WB_VICTIM, EPF_OP_ZERO};
   localparam logic [8:0] E_PWI = {EPF_OP_PROBE, EPF_OP_WB_INVAL, EPF_OP_PROBE};
   localparam logic [8:0] E_PI = {EPF_OP_PROBE, EPF_OP_INVAL, EPF_OP_PROBE};
   logic [4:0] fh[6] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07};
   logic [4:0] rh[6] = '{5'h02, 5'h03, 5'h08, 5'h14, 5'h15, 5'h1f};
   always #20 clock = ~clock;
   assign hready = hreadyout;
   // Attribute lines carry garbage outside their valid pulse, so stale values cannot pass.
   assign {xlat_seg_mode, xlat_hit, xlat_fault, xlat_cached, xlat_coherent, xlat_attr, xlat_paddr} =
      xlat_resp_valid ? {t_seg, t_hit, t_flt, t_cac, t_coh, t_attr, t_pa} : ~{t_seg, t_hit, t_flt, t_cac, t_coh, t_attr, t_pa};
   assign {probe_hit, probe_dirty, probe_locked, victim_valid, victim_dirty, victim_locked, cache_err} =
      cache_done ? pv_q : ~pv_q;
   epf_prefetch_unit i_dut (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hrdata, .hresp, .issue_valid, .issue_ready, .instr_word, .base_value,
      .system_control_coprocessor_en, .done_valid, .done_match, .done_exc, .xlat_req_valid, .xlat_vaddr,
      .xlat_user_map, .xlat_resp_valid, .xlat_seg_mode, .xlat_hit, .xlat_fault, .xlat_cached, .xlat_coherent,
      .xlat_attr, .xlat_paddr, .order_clear, .cache_req_valid, .cache_req_ready, .cache_req_op, .cache_req_paddr,
      .cache_req_attr, .cache_req_coherent, .cache_req_place, .cache_req_store, .cache_done, .cache_err,
      .probe_hit, .probe_dirty, .probe_locked, .victim_valid, .victim_dirty, .victim_locked);
   epf_far_model i_far (.clock, .sys_rst, .slow, .xlat_req_valid, .xlat_resp_valid, .cache_req_valid,
      .cache_req_ready, .cache_done);
   // ==========
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic ahb(input logic [4:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {27'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
      check(32'(hresp), 32'h0);
   endtask
   function automatic logic [31:0] mk(input logic [4:0] h, input logic [8:0] o);
      return {EPF_MAJOR, h, 5'h03, EPF_GRP, EPF_SUB, o};
   endfunction
   task automatic run(input logic [31:0] iw, input logic [6:0] pv, input epf_exc_t ex, input logic mt,
      input int n, input logic [8:0] eo);
      int k;
      ops.delete();
      exp_va = t_base + {{23{iw[8]}}, iw[8:0]};
      pv_q <= pv;
      instr_word <= iw;
      base_value <= t_base;
      issue_valid <= 1'b1;
      do @(posedge clock); while (issue_ready !== 1'b1);
      issue_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (done_valid !== 1'b1 && k < 200);
      check(32'(done_valid), 32'h1);
      check(32'(done_exc), 32'(ex));
      check(32'(done_match), 32'(mt));
      check(32'(ops.size()), 32'(n));
      for (k = 0; k < n; k++) check(32'(ops[k]), 32'(eo[8-3*k -: 3]));
   endtask
   always @(posedge clock) begin
      if (cache_req_valid && cache_req_ready) begin
         ops.push_back(cache_req_op);
         check(cache_req_paddr, t_pa);
         check(32'(cache_req_attr), 32'(t_attr));
         check(32'(cache_req_coherent), 32'(t_coh));
         if (cache_req_op === EPF_OP_FETCH) begin
            check(32'(cache_req_place), 32'(t_pl));
            check(32'(cache_req_store), 32'(t_st));
         end
      end
      if (xlat_resp_valid) begin
         check(xlat_vaddr, exp_va);
         check(32'(xlat_user_map), 32'h1);
      end
      if (!order_clear) check(32'(cache_req_valid), 32'h0);
   end
   initial begin
      repeat (6000) @(posedge clock);
      bad_count++;
      end_of_test();
   end
   // ==========
   // Tests
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      ahb({1'b0, EPF_REG_CTRL}, 0, 0, d);
      check(d, 32'(EPF_CTRL_RST));
      ahb(5'h10, 1, 32'hffffffff, d);
      ahb(5'h10, 0, 0, d);
      check(d, 32'h0);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h7, d);
      ahb({1'b0, EPF_REG_CTRL}, 0, 0, d);
      check(d, 32'h7);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h1, d);
      $display("test registers done");
      run(mk(5'h00, 9'h0) ^ 32'h200, 7'h0, EPF_EXC_NONE, 0, 0, 9'h0);
      order_clear <= 1'b0;
      fork
         begin
            repeat (8) @(posedge clock);
            order_clear <= 1'b1;
         end
      join_none
      foreach (fh[i]) begin
         t_st <= fh[i][0];
         t_pl <= (fh[i][2:1] == 2'b10) ? EPF_PL_STREAM : (fh[i][2:1] == 2'b11) ? EPF_PL_RETAIN : EPF_PL_NORMAL;
         slow <= i[0];
         run(mk(fh[i], 9'h1f0), 7'h0, EPF_EXC_NONE, 1, 2, E_PF);
      end
      run(mk(5'h00, 9'h004), 7'h40, EPF_EXC_NONE, 1, 1, E_P);
      $display("test fetch hints done");
      run(mk(EPF_H_ZERO, 9'h0ff), 7'h0c, EPF_EXC_NONE, 1, 3, E_PWZ);
      run(mk(EPF_H_ZERO, 9'h0), 7'h40, EPF_EXC_NONE, 1, 1, E_P);
      run(mk(EPF_H_ZERO, 9'h0), 7'h0e, EPF_EXC_NONE, 1, 1, E_P);
      run(mk(EPF_H_WBINV, 9'h100), 7'h60, EPF_EXC_NONE, 1, 2, E_PWI);
      run(mk(EPF_H_WBINV, 9'h0), 7'h70, EPF_EXC_NONE, 1, 1, E_P);
      run(mk(EPF_H_WBINV, 9'h0), 7'h40, EPF_EXC_NONE, 1, 1, E_P);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h5, d);
      run(mk(EPF_H_WBINV, 9'h0), 7'h40, EPF_EXC_NONE, 1, 2, E_PI);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h1, d);
      $display("test line actions done");
      foreach (rh[i]) run(mk(rh[i], 9'h0), 7'h0, EPF_EXC_NONE, 1, 0, 9'h0);
      t_cac <= 1'b0;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_NONE, 1, 0, 9'h0);
      t_cac <= 1'b1;
      t_coh <= 1'b0;
      t_st <= 1'b0;
      t_pl <= EPF_PL_NORMAL;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_NONE, 1, 2, E_PF);
      t_coh <= 1'b1;
      // Error reporting off: the cache error is swallowed; on: it becomes a bus error.
      run(mk(5'h00, 9'h0), 7'h01, EPF_EXC_NONE, 1, 2, E_PF);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h3, d);
      run(mk(5'h00, 9'h0), 7'h01, EPF_EXC_BUS, 1, 2, E_PF);
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h1, d);
      ahb({1'b0, EPF_REG_SUPP}, 1, 0, d);
      ahb({1'b0, EPF_REG_EXEC}, 1, 0, d);
      t_flt <= 1'b1;
      run(mk(5'h01, 9'h0), 7'h0, EPF_EXC_NONE, 1, 0, 9'h0);
      t_flt <= 1'b0;
      t_hit <= 1'b0;
      run(mk(5'h01, 9'h0), 7'h0, EPF_EXC_NONE, 1, 0, 9'h0);
      t_hit <= 1'b1;
      ahb({1'b0, EPF_REG_STAT}, 0, 0, d);
      check(d, 32'h8);
      ahb({1'b0, EPF_REG_SUPP}, 0, 0, d);
      check(d, 32'h2);
      ahb({1'b0, EPF_REG_EXEC}, 0, 0, d);
      check(d, 32'h2);
      $display("test suppression done");
      t_seg <= 3'h0;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_RI, 1, 0, 9'h0);
      t_seg <= EPF_SEG_UNMAPPED;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_NONE, 1, 2, E_PF);
      t_seg <= EPF_SEG_MAPPED;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_NONE, 1, 2, E_PF);
      system_control_coprocessor_en <= 1'b0;
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_CPU, 1, 0, 9'h0);
      system_control_coprocessor_en <= 1'b1;
      ahb({1'b0, EPF_REG_CTRL}, 1, 32'h0, d);
      run(mk(5'h00, 9'h0), 7'h0, EPF_EXC_RI, 1, 0, 9'h0);
      ahb({1'b0, EPF_REG_STAT}, 0, 0, d);
      check(d, 32'h2);
      $display("test exceptions done");
      end_of_test();
   end
endmodule
